// [test/link_partner_model.sv]
/*
  Far end of the serial lane: sends OOB burst trains and answers receiver detection.
  Assumes the bench calls send_com and sets present.
*/
`include "serdes_oob_cfg.svh"

module link_partner_model (
  // Clock
  input wire logic mclk,
  // Line
  input wire logic rxDetectDrive,
  input wire logic present,
  output logic lineActiveRaw,
  output logic partnerPresentRaw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lineActiveRaw = 1'b0;
  assign partnerPresentRaw = present & rxDetectDrive;
  // bursts split by init, wake or SAS gaps
  task automatic send_com(input int gap, input int n);
    for (int i = 0; i < n; i++) begin
      lineActiveRaw <= 1'b1;
      repeat (`NS_MIN_CYC(`OOB_BURST_NS)) @(posedge mclk);
      lineActiveRaw <= 1'b0;
      if (i < n - 1) repeat (gap) @(posedge mclk);
    end
  endtask : send_com
endmodule : link_partner_model

// [test/serdes_oob_checker.sv]
/*
  Port-level checker for the lane controller, bound to its top module.
  Assumes one clock, mclk, and the synchronous high reset srst.
*/
module serdes_oob_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Watched ports
  input wire logic hresp,
  input wire logic [2:0] loopback_mode,
  input wire logic [2:0] loopbackSel,
  input wire logic [31:0] decWord,
  input wire logic [31:0] rx_word,
  input wire logic [3:0] decKFlags,
  input wire logic [3:0] rx_kchar_flags,
  input wire logic symbolLock,
  input wire logic rx_symbol_valid,
  input wire logic oob_init_detected,
  input wire logic oob_sas_detected,
  input wire logic oob_wake_detected,
  input wire logic oob_send_done,
  input wire logic phy_op_done,
  input wire logic tx_idle_force,
  input wire logic txLineIdle,
  input wire logic txLineBurst
);
  wire logic [2:0] det = {oob_init_detected, oob_sas_detected, oob_wake_detected};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  loop_copy_a: assert property (!$past(srst) |-> loopbackSel == $past(loopback_mode))
    else $error("loopback select does not follow");
  rx_copy_a: assert property (!$past(srst) |-> rx_word == $past(decWord))
    else $error("receive word does not follow");
  kflag_copy_a: assert property (!$past(srst) |-> rx_kchar_flags == $past(decKFlags))
    else $error("K flags do not follow");
  valid_lock_a: assert property (rx_symbol_valid |-> $past(symbolLock))
    else $error("valid without lock");
  det_onehot_a: assert property ($onehot0(det))
    else $error("two detect flags at once");
  det_pulse_a: assert property (det != 3'h0 |=> det == 3'h0)
    else $error("detect flag held");
  idle_force_a: assert property ((tx_idle_force && !txLineBurst) [*3] |-> txLineIdle)
    else $error("line not idle when forced");
  done_burst_a: assert property (oob_send_done |-> !txLineBurst ##1 !oob_send_done)
    else $error("send done during burst or held");
  phy_pulse_a: assert property (phy_op_done |=> !phy_op_done)
    else $error("phy status held");
  bus_okay_a: assert property (!hresp)
    else $error("bus response not okay");
  cover property (oob_init_detected);
  cover property (oob_send_done);
  cover property (phy_op_done);
endmodule : serdes_oob_checker

bind serdes_oob_power_control serdes_oob_checker chk (.mclk, .srst, .hresp, .loopback_mode, .loopbackSel,
  .decWord, .rx_word, .decKFlags, .rx_kchar_flags, .symbolLock, .rx_symbol_valid, .oob_init_detected, .oob_sas_detected,
  .oob_wake_detected, .oob_send_done, .phy_op_done, .tx_idle_force, .txLineIdle, .txLineBurst);

// [test/tb.sv]
/*
  Self-checking bench for the lane controller: bus, power timing, detection, OOB send and receive.
  Assumes the partner model and the bound checker are compiled with it.
*/
`include "serdes_oob_cfg.svh"

module tb import serdes_oob_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SET = 2;
  logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, present = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00, tx_power_state = PWR_P0, rx_power_state = PWR_P0;
  logic [2:0] hsize = 3'h2, loopback_mode = 3'h0, rx_status_code;
  logic [31:0] hwdata = 32'h0, decWord = 32'h0, hrdata, rx_word;
  logic [3:0] decKFlags = 4'h0, rx_kchar_flags;
  logic receiver_detect_req = 1'b0, tx_idle_force = 1'b0, tx_disp_mode = 1'b0, tx_disp_value = 1'b0;
  logic oob_send_init = 1'b0, oob_send_sas = 1'b0, oob_send_wake = 1'b0, symbolLock = 1'b0;
  logic hreadyout, hresp, rx_symbol_valid, oob_init_detected, oob_sas_detected, oob_wake_detected;
  logic oob_send_done, phy_op_done, lineActiveRaw, partnerPresentRaw;
  logic txLineIdle, txLineBurst, txDispInvert, rxDetectDrive;
  logic [2:0] loopbackSel;
  wire logic hready = hreadyout;
  int nMismatch = 0, totalChecks = 0;

  serdes_oob_power_control #(.SETTLE_CYC(SET)) dut (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .loopback_mode, .tx_power_state,
    .rx_power_state, .receiver_detect_req, .tx_idle_force, .tx_disp_mode, .tx_disp_value,
    .oob_send_init, .oob_send_sas, .oob_send_wake, .rx_status_code, .rx_symbol_valid, .rx_word,
    .rx_kchar_flags, .oob_init_detected, .oob_sas_detected, .oob_wake_detected, .oob_send_done,
    .phy_op_done, .symbolLock, .decWord, .decKFlags, .lineActiveRaw, .partnerPresentRaw,
    .txLineIdle, .txLineBurst, .txDispInvert, .loopbackSel, .rxDetectDrive);
  link_partner_model u_partner (.mclk, .rxDetectDrive, .present, .lineActiveRaw, .partnerPresentRaw);

  initial forever #5 mclk = ~mclk;
  // Decoder traffic keeps the copy paths busy
  always @(posedge mclk) if (!srst) begin
    decWord <= decWord + 32'h01030507;
    decKFlags <= decWord[7:4];
    symbolLock <= decWord[9];
    loopback_mode <= decWord[14:12];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1 && ++n < 50);
    rd = hrdata;
  endtask : bus

  // Counts cycles from driving a request until phy_op_done shows
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (phy_op_done !== 1'b1 && n < 200);
  endtask : wait_done

  task automatic pwr(input power_t s, input int lim);
    int n;
    @(posedge mclk);
    tx_power_state <= s;
    rx_power_state <= s;
    wait_done(n);
    chk(n, lim + 3);
  endtask : pwr

  task automatic det(input logic p, input logic [2:0] code, input logic sata);
    int n;
    @(posedge mclk);
    present <= p;
    tx_idle_force <= 1'b1;
    receiver_detect_req <= 1'b1;
    wait_done(n);
    chk(n, sata ? 200 : SET + 3);
    @(negedge mclk);
    if (!sata) chk(rx_status_code, code);
    @(posedge mclk);
    receiver_detect_req <= 1'b0;
    tx_idle_force <= 1'b0;
  endtask : det

  task automatic orx(input int gap, input int n, input logic [2:0] exp, input logic sata);
    logic [2:0] seen, st;
    seen = 3'h0;
    st = 3'h0;
    fork
      u_partner.send_com(gap, n);
      repeat (n * (11 + gap) + 30) begin
        @(negedge mclk);
        seen |= {oob_init_detected, oob_sas_detected, oob_wake_detected};
        st |= rx_status_code;
      end
    join
    chk(seen, exp);
    // SATA status packs sas, init, wake; PCI Express shows no detection here
    chk(st, sata ? {exp[1], exp[2], exp[0]} : 3'h0);
  endtask : orx

  task automatic otx(input logic [2:0] req);
    int b, n;
    logic prev;
    b = 0;
    n = 0;
    prev = 1'b0;
    @(posedge mclk);
    {oob_send_init, oob_send_sas, oob_send_wake} <= req;
    @(posedge mclk);
    {oob_send_init, oob_send_sas, oob_send_wake} <= 3'h0;
    do begin
      @(negedge mclk);
      n++;
      if (txLineBurst && !prev) b++;
      prev = txLineBurst;
    end while (oob_send_done !== 1'b1 && n < 3000);
    chk(b, `OOB_TX_BURSTS);
    chk(oob_send_done, 1'b1);
  endtask : otx

  task automatic finish_test;
    if (nMismatch == 0 && totalChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #300us;
    nMismatch++;
    finish_test;
  end

  initial begin
    logic [31:0] r;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    pwr(PWR_P1, 197);
    pwr(PWR_P0, 197);
    bus(1'b0, `REG_TO_P2, 32'h0, r);
    chk(r, {16'h0, `RST_TO_P2});
    bus(1'b0, 12'h100, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b1, `REG_CTRL, {24'h0, `RST_IDLES, `RST_BURSTS, 2'b01}, r);
    bus(1'b0, `REG_CTRL, 32'h0, r);
    chk(r, {24'h0, `RST_IDLES, `RST_BURSTS, 2'b01});
    bus(1'b1, `REG_NON_P2, 32'h5, r);
    bus(1'b1, `REG_TO_P2, 32'h8, r);
    bus(1'b1, `REG_FROM_P2, 32'h6, r);
    pwr(PWR_P1, 5);
    pwr(PWR_P2, 8);
    pwr(PWR_P1, 6);
    det(1'b1, `STAT_PCIE_DETECTED, 1'b0);
    det(1'b0, `STAT_PCIE_OK, 1'b0);
    bus(1'b1, `REG_CTRL, {24'h0, `RST_IDLES, `RST_BURSTS, 2'b11}, r);
    det(1'b1, 3'h0, 1'b1);
    orx(32, 5, 3'b100, 1'b1);
    orx(11, 5, 3'b001, 1'b1);
    orx(96, 5, 3'b010, 1'b1);
    orx(32, 3, 3'b000, 1'b1);
    bus(1'b1, `REG_CTRL, {24'h0, 3'h1, 3'h2, 2'b01}, r);
    orx(11, 2, 3'b001, 1'b0);
    otx(3'b100);
    otx(3'b010);
    otx(3'b001);
    finish_test;
  end
endmodule : tb

// [verilog/serdes_oob_cfg.svh]
/*
  Constants of the lane out-of-band and power-state controller: register map, field positions,
  reset values and line timing. Assumes a 100 MHz mclk; the testbench includes this file too.
*/
// What this block does
// RQ1: COM match needs a programmable burst count, 0 to 7, default 4.
// RQ2: COM match also needs a programmable idle count, 0 to 7.
// RQ3: A counted idle is a gap of init/reset length or of wake length; the code also counts gaps of SAS length.
// RQ4: PCI Express option enables power-down modes and bonding-specific operations; the code has no bonding-specific logic.
// RQ5: Entry to P2 is timed by a 16-bit counter, default 100.
// RQ6: Exit from P2 is timed by a separate 16-bit counter, default 60.
// RQ7: Other power changes use a third 16-bit counter, default 25.
// RQ8: A 3-bit loopback input selects the data loopback test mode.
// RQ9: A 3-bit receiver status code follows the selected encoding, PCI Express or SATA.
// RQ10: Receive valid rises with symbol lock and valid data plus K flags.
// RQ11: Separate high outputs flag init, SAS and wake COM detection.
// RQ12: Receiver-detect request starts detection, gated by power, idle and disparity inputs.
// RQ13: Receiver-detect request is ignored when status encoding is SATA.
// RQ14: Electrical-idle input forces zero differential output, qualified in PCI Express mode; the code forces idle in any mode, except while a burst goes out.
// RQ15: PHY status pulses when detection or a power change completes.
// RQ16: Controlling logic drives separate transmit and receive power-down inputs.
// RQ17: After an OOB send request, a done pulse follows the last burst sent.
// RQ18: Each power counter counts cycles from the change start to its programmed value.
`ifndef SERDES_OOB_CFG_SVH
`define SERDES_OOB_CFG_SVH

`define MCLK_MHZ 100
// Least time rounds up, longest rounds down
`define NS_MIN_CYC(ns) ((((ns) * `MCLK_MHZ) + 999) / 1000)
`define NS_MAX_CYC(ns) (((ns) * `MCLK_MHZ) / 1000)

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_TO_P2 12'h004
`define REG_FROM_P2 12'h008
`define REG_NON_P2 12'h00c
`define REG_STATUS 12'h010

// Control fields
`define CTRL_PCIE_BIT 0
`define CTRL_FMT_SATA_BIT 1
`define CTRL_BURST_LSB 2
`define CTRL_IDLE_LSB 5
`define CTRL_FIELD_W 3

// Reset values
`define RST_PCIE 1'b0
`define RST_FMT_SATA 1'b0
`define RST_BURSTS 3'h4
`define RST_IDLES 3'h4
`define RST_TO_P2 16'h0064
`define RST_FROM_P2 16'h003c
`define RST_NON_P2 16'h0019

// Line timing in ns, and the burst count of a sent train
`define OOB_BURST_NS 107
`define INIT_GAP_MIN_NS 304
`define INIT_GAP_MAX_NS 336
`define WAKE_GAP_MIN_NS 101
`define WAKE_GAP_MAX_NS 112
`define SAS_GAP_MIN_NS 912
`define SAS_GAP_MAX_NS 1008
`define INIT_GAP_TX_NS 320
`define WAKE_GAP_TX_NS 107
`define SAS_GAP_TX_NS 960
`define RXDET_SETTLE_NS 200
`define OOB_TX_BURSTS 4

// PCI Express status codes
`define STAT_PCIE_OK 3'h0
`define STAT_PCIE_DETECTED 3'h3

`endif

// [verilog/serdes_oob_pkg.sv]
/*
  Types shared by the lane controller and its bench. Assumes nothing beyond the compiler.
*/
package serdes_oob_pkg;
  typedef enum logic [1:0] {PWR_P0 = 2'b00, PWR_P0S = 2'b01, PWR_P1 = 2'b10, PWR_P2 = 2'b11} power_t;
  typedef enum logic [1:0] {OOB_INIT, OOB_WAKE, OOB_SAS, OOB_NONE} oob_kind_t;
  typedef enum {TX_IDLE, TX_BURST, TX_GAP} tx_state_t;
  typedef enum {PW_IDLE, PW_TIMING, PW_DETECT} pw_state_t;
endpackage : serdes_oob_pkg

// [verilog/serdes_oob_power_control.sv]
/*
  Out-of-band signalling and power-state control for one serial lane, with an AHB-Lite register slave.
  Assumes lineActiveRaw and partnerPresentRaw come from analog comparators (asynchronous);
  rx decoder inputs and user inputs are on mclk.
*/
`include "serdes_oob_cfg.svh"

module serdes_oob_power_control
  import serdes_oob_pkg::*;
#(
  parameter int SETTLE_CYC = `NS_MIN_CYC(`RXDET_SETTLE_NS)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // User control
  input wire logic [2:0] loopback_mode,
  input wire logic [1:0] tx_power_state,
  input wire logic [1:0] rx_power_state,
  input wire logic receiver_detect_req,
  input wire logic tx_idle_force,
  input wire logic tx_disp_mode,
  input wire logic tx_disp_value,
  input wire logic oob_send_init,
  input wire logic oob_send_sas,
  input wire logic oob_send_wake,
  // User status
  output logic [2:0] rx_status_code,
  output logic rx_symbol_valid,
  output logic [31:0] rx_word,
  output logic [3:0] rx_kchar_flags,
  output logic oob_init_detected,
  output logic oob_sas_detected,
  output logic oob_wake_detected,
  output logic oob_send_done,
  output logic phy_op_done,
  // Receive decoder, same clock
  input wire logic symbolLock,
  input wire logic [31:0] decWord,
  input wire logic [3:0] decKFlags,
  // Analog line side
  input wire logic lineActiveRaw,
  input wire logic partnerPresentRaw,
  output logic txLineIdle,
  output logic txLineBurst,
  output logic txDispInvert,
  output logic [2:0] loopbackSel,
  output logic rxDetectDrive
);
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(`NS_MIN_CYC(`OOB_BURST_NS));
  localparam logic [CNT_W-1:0] INIT_MIN = CNT_W'(`NS_MIN_CYC(`INIT_GAP_MIN_NS));
  localparam logic [CNT_W-1:0] INIT_MAX = CNT_W'(`NS_MAX_CYC(`INIT_GAP_MAX_NS));
  localparam logic [CNT_W-1:0] WAKE_MIN = CNT_W'(`NS_MIN_CYC(`WAKE_GAP_MIN_NS));
  localparam logic [CNT_W-1:0] WAKE_MAX = CNT_W'(`NS_MAX_CYC(`WAKE_GAP_MAX_NS));
  localparam logic [CNT_W-1:0] SAS_MIN = CNT_W'(`NS_MIN_CYC(`SAS_GAP_MIN_NS));
  localparam logic [CNT_W-1:0] SAS_MAX = CNT_W'(`NS_MAX_CYC(`SAS_GAP_MAX_NS));
  localparam logic [CNT_W-1:0] SETTLE = CNT_W'(SETTLE_CYC);

  function automatic logic [CNT_W-1:0] txGapLen(input oob_kind_t k);
    unique case (k)
      OOB_INIT: txGapLen = CNT_W'(`NS_MIN_CYC(`INIT_GAP_TX_NS));
      OOB_WAKE: txGapLen = CNT_W'(`NS_MIN_CYC(`WAKE_GAP_TX_NS));
      default: txGapLen = CNT_W'(`NS_MIN_CYC(`SAS_GAP_TX_NS));
    endcase
  endfunction : txGapLen

  // Registers
  logic pcieEn_q, fmtSata_q;
  logic [2:0] burstCnt_q, idleCnt_q;
  logic [15:0] toP2_q, fromP2_q, nonP2_q;
  // Bus
  logic wrPend_q;
  logic [11:0] addr_q;
  // Synchronisers
  logic [1:0] lineSync_q, partSync_q;
  logic lineActive, partnerPresent, linePrev_q;
  // OOB receive
  logic [CNT_W-1:0] gapLen_q;
  logic [2:0] burstsSeen_q, idlesSeen_q;
  oob_kind_t rxKind_q;
  logic initDet_q, sasDet_q, wakeDet_q;
  // OOB transmit
  tx_state_t txState_q;
  oob_kind_t txKind_q;
  logic [CNT_W-1:0] txCnt_q;
  logic [2:0] txBursts_q;
  logic sendDone_q;
  // Power
  pw_state_t pwState_q;
  power_t curPower_q, tgtPower_q;
  logic [15:0] pwCnt_q, pwLimit_q;
  logic phyDone_q, detected_q, detHeld_q;
  logic [2:0] status_q;
  logic rx_symbol_valid_q;
  logic [31:0] rxWord_q;
  logic [3:0] rxK_q;
  logic [2:0] loop_q;

  // Bus decode
  wire busReq = hsel & hready & htrans[1];
  wire busWr = busReq & hwrite;
  wire [31:0] ctrlWord = {24'h000000, idleCnt_q, burstCnt_q, fmtSata_q, pcieEn_q};
  wire [31:0] statWord = {23'h000000, detected_q, rx_symbol_valid_q, status_q, curPower_q,
                          pwState_q != PW_IDLE, txState_q != TX_IDLE};
  // Decoded from the address phase so the word stands for the whole data phase
  wire [31:0] rdMux = (haddr == `REG_CTRL) ? ctrlWord :
                      (haddr == `REG_TO_P2) ? {16'h0000, toP2_q} :
                      (haddr == `REG_FROM_P2) ? {16'h0000, fromP2_q} :
                      (haddr == `REG_NON_P2) ? {16'h0000, nonP2_q} :
                      (haddr == `REG_STATUS) ? statWord : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPend_q <= 1'b0;
      addr_q <= 12'h000;
      hrdata <= 32'h00000000;
    end else begin
      wrPend_q <= busWr;
      if (busReq) begin
        addr_q <= haddr;
      end
      if (busReq & ~hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pcieEn_q <= `RST_PCIE;
      fmtSata_q <= `RST_FMT_SATA;
      burstCnt_q <= `RST_BURSTS;
      idleCnt_q <= `RST_IDLES;
      toP2_q <= `RST_TO_P2;
      fromP2_q <= `RST_FROM_P2;
      nonP2_q <= `RST_NON_P2;
    end else if (wrPend_q) begin
      unique case (addr_q)
        `REG_CTRL: begin
          pcieEn_q <= hwdata[`CTRL_PCIE_BIT];
          fmtSata_q <= hwdata[`CTRL_FMT_SATA_BIT];
          burstCnt_q <= hwdata[`CTRL_BURST_LSB +: `CTRL_FIELD_W];
          idleCnt_q <= hwdata[`CTRL_IDLE_LSB +: `CTRL_FIELD_W];
        end
        `REG_TO_P2: toP2_q <= hwdata[15:0];
        `REG_FROM_P2: fromP2_q <= hwdata[15:0];
        `REG_NON_P2: nonP2_q <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Line inputs pass two flops first
  always_ff @(posedge mclk) begin
    if (srst) begin
      lineSync_q <= 2'b00;
      partSync_q <= 2'b00;
      linePrev_q <= 1'b0;
    end else begin
      lineSync_q <= {lineSync_q[0], lineActiveRaw};
      partSync_q <= {partSync_q[0], partnerPresentRaw};
      linePrev_q <= lineActive;
    end
  end
  assign lineActive = lineSync_q[1];
  assign partnerPresent = partSync_q[1];

  // RQ3 gap classification
  wire burstStart = lineActive & ~linePrev_q;
  wire gapIsInit = gapLen_q >= INIT_MIN && gapLen_q <= INIT_MAX;
  wire gapIsWake = gapLen_q >= WAKE_MIN && gapLen_q <= WAKE_MAX;
  wire gapIsSas = gapLen_q >= SAS_MIN && gapLen_q <= SAS_MAX;
  wire oob_kind_t gapKind = gapIsInit ? OOB_INIT : gapIsWake ? OOB_WAKE : gapIsSas ? OOB_SAS : OOB_NONE;
  wire firstBurst = burstsSeen_q == 3'h0;
  wire kindOk = gapKind != OOB_NONE && (idlesSeen_q == 3'h0 || gapKind == rxKind_q);
  // The stored kind lags by one burst; the gap just closed names the train
  wire oob_kind_t matchKind = kindOk ? gapKind : rxKind_q;
  wire [2:0] nextBursts = (burstsSeen_q == 3'h7) ? 3'h7 : burstsSeen_q + 3'h1;
  wire [2:0] nextIdles = (firstBurst || !kindOk) ? 3'h0 : (idlesSeen_q == 3'h7) ? 3'h7 : idlesSeen_q + 3'h1;
  // RQ1 RQ2 match needs both counts
  wire comMatch = burstStart && nextBursts >= burstCnt_q && nextIdles >= idleCnt_q && (firstBurst || kindOk);
  wire gapTooLong = gapLen_q > SAS_MAX;

  always_ff @(posedge mclk) begin
    if (srst) begin
      gapLen_q <= '0;
      burstsSeen_q <= 3'h0;
      idlesSeen_q <= 3'h0;
      rxKind_q <= OOB_NONE;
      initDet_q <= 1'b0;
      sasDet_q <= 1'b0;
      wakeDet_q <= 1'b0;
    end else begin
      gapLen_q <= lineActive ? '0 : (gapTooLong ? gapLen_q : gapLen_q + 1'b1);
      // A burst after an over-long gap still counts as the first of a train
      if (burstStart) begin
        burstsSeen_q <= (firstBurst || kindOk) ? nextBursts : 3'h1;
        idlesSeen_q <= nextIdles;
        if (kindOk) begin
          rxKind_q <= gapKind;
        end
      end else if (gapTooLong) begin
        burstsSeen_q <= 3'h0;
        idlesSeen_q <= 3'h0;
      end
      // RQ11 one pulse per match
      initDet_q <= comMatch && matchKind == OOB_INIT;
      sasDet_q <= comMatch && matchKind == OOB_SAS;
      wakeDet_q <= comMatch && matchKind == OOB_WAKE;
    end
  end

  // OOB transmitter
  wire sendReq = oob_send_init | oob_send_sas | oob_send_wake;
  wire oob_kind_t reqKind = oob_send_init ? OOB_INIT : oob_send_wake ? OOB_WAKE : OOB_SAS;

  always_ff @(posedge mclk) begin
    if (srst) begin
      txState_q <= TX_IDLE;
      txKind_q <= OOB_NONE;
      txCnt_q <= '0;
      txBursts_q <= 3'h0;
      sendDone_q <= 1'b0;
    end else begin
      sendDone_q <= 1'b0;
      unique case (txState_q)
        TX_IDLE: if (sendReq) begin
          txState_q <= TX_BURST;
          txKind_q <= reqKind;
          txCnt_q <= BURST_CYC;
          txBursts_q <= 3'h0;
        end
        TX_BURST: if (txCnt_q == CNT_W'(1)) begin
          txState_q <= TX_GAP;
          txCnt_q <= txGapLen(txKind_q);
          txBursts_q <= txBursts_q + 3'h1;
        end else begin
          txCnt_q <= txCnt_q - 1'b1;
        end
        TX_GAP: if (txCnt_q != CNT_W'(1)) begin
          txCnt_q <= txCnt_q - 1'b1;
        end else if (txBursts_q == 3'(`OOB_TX_BURSTS)) begin
          txState_q <= TX_IDLE;
          // RQ17 done after last gap
          sendDone_q <= 1'b1;
        end else begin
          txState_q <= TX_BURST;
          txCnt_q <= BURST_CYC;
        end
      endcase
    end
  end

  // RQ4 power inputs only act with PCI Express enabled
  wire power_t reqPower = pcieEn_q ? power_t'(tx_power_state) : PWR_P0;
  // RQ5 RQ6 RQ7 counter selection
  wire [15:0] limitSel = (reqPower == PWR_P2) ? toP2_q : (curPower_q == PWR_P2) ? fromP2_q : nonP2_q;
  // RQ12 RQ13 detection only in P1, idle, normal disparity and PCI Express encoding
  wire detStart = receiver_detect_req && pcieEn_q && !fmtSata_q && curPower_q == PWR_P1
                  && tx_idle_force && !tx_disp_mode && !detHeld_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pwState_q <= PW_IDLE;
      curPower_q <= PWR_P0;
      tgtPower_q <= PWR_P0;
      pwCnt_q <= 16'h0000;
      pwLimit_q <= 16'h0000;
      phyDone_q <= 1'b0;
      detected_q <= 1'b0;
      detHeld_q <= 1'b0;
    end else begin
      phyDone_q <= 1'b0;
      // A level request held past its answer must drop before it starts another probe
      if (!receiver_detect_req) begin
        detHeld_q <= 1'b0;
      end
      unique case (pwState_q)
        PW_IDLE: if (reqPower != curPower_q) begin
          pwState_q <= PW_TIMING;
          tgtPower_q <= reqPower;
          pwLimit_q <= limitSel;
          pwCnt_q <= 16'h0000;
        end else if (detStart) begin
          pwState_q <= PW_DETECT;
          pwCnt_q <= 16'h0000;
        end
        // RQ18 count to programmed value
        PW_TIMING: if (pwCnt_q >= pwLimit_q) begin
          pwState_q <= PW_IDLE;
          curPower_q <= tgtPower_q;
          // RQ15 power change complete
          phyDone_q <= 1'b1;
        end else begin
          pwCnt_q <= pwCnt_q + 16'h0001;
        end
        PW_DETECT: if (pwCnt_q[CNT_W-1:0] >= SETTLE) begin
          pwState_q <= PW_IDLE;
          detected_q <= partnerPresent;
          detHeld_q <= 1'b1;
          // RQ15 detection complete
          phyDone_q <= 1'b1;
        end else begin
          pwCnt_q <= pwCnt_q + 16'h0001;
        end
      endcase
    end
  end

  // RQ9 status encoding per format
  wire [2:0] pcieStatus = (phyDone_q && pwState_q == PW_IDLE && detected_q) ? `STAT_PCIE_DETECTED : `STAT_PCIE_OK;
  wire [2:0] sataStatus = {sasDet_q, initDet_q, wakeDet_q};
  wire rxPowered = rx_power_state == PWR_P0 || !pcieEn_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= 3'h0;
      rx_symbol_valid_q <= 1'b0;
      rxWord_q <= 32'h00000000;
      rxK_q <= 4'h0;
      loop_q <= 3'h0;
    end else begin
      status_q <= fmtSata_q ? sataStatus : pcieStatus;
      // RQ10 valid with lock
      rx_symbol_valid_q <= symbolLock & rxPowered;
      rxWord_q <= decWord;
      rxK_q <= decKFlags;
      // RQ8 loopback select
      loop_q <= loopback_mode;
    end
  end

  assign rx_status_code = status_q;
  assign rx_symbol_valid = rx_symbol_valid_q;
  assign rx_word = rxWord_q;
  assign rx_kchar_flags = rxK_q;
  assign oob_init_detected = initDet_q;
  assign oob_sas_detected = sasDet_q;
  assign oob_wake_detected = wakeDet_q;
  assign oob_send_done = sendDone_q;
  assign phy_op_done = phyDone_q;
  assign loopbackSel = loop_q;
  assign txLineBurst = txState_q == TX_BURST;
  // RQ14 idle when forced or powered down, but bursts still go out
  assign txLineIdle = !txLineBurst && (tx_idle_force || curPower_q != PWR_P0);
  assign txDispInvert = pcieEn_q && tx_disp_mode && tx_disp_value;
  assign rxDetectDrive = pwState_q == PW_DETECT;
endmodule : serdes_oob_power_control
